/* File: logic/fepp_pkg.sv */
// Constants for the serial flash erase, program and protection sequencer.
// Assumes a mode-0/3 serial host and a 40 MHz system clock.
// How it works
// (R1) Chip erase opcodes C7 94 80 9A.
// (R2) Bytes after erase opcode are ignored.
// (R3) Chip select rise starts self-timed erase.
// (R4) Busy stays set until cycle ends.
// (R5) Erase skips protected or locked sectors.
// (R6) Write-protect activation deferred during erase.
// (R7) Opcode 82 buffer one, 85 buffer two.
// (R8) 264-byte pages: 3 dc, 12 page, 9 offset.
// (R9) 256-byte pages: 4 dc, 12 page, 8 offset.
// (R10) Data fills buffer, wrapping at the end.
// (R11) Chip select rise erases then programs page.
// (R12) Enable protection 3D 2A 7F A9.
// (R13) Disable protection 3D 2A 7F 9A.
// (R14) Disable ignored while write-protect asserted.
// (R15) Reset clears software protection state.
// (R16) Floating write-protect reads as deasserted.
// (R17) Write-protect blocks map and protected sectors.
// (R18) Write-protect enables protection within bounded delay.
// (R19) Pin release drops protection unless enabled.
// (R20) Write-protect input is noise filtered.
// (R21) Status shows protection enabled.
// (R22) Protection blocks writes to marked sectors.
// (R23) Map byte FF protects, 00 unprotects.
// (R24) Sector zero bits split 0a, 0b.
// (R25) Page top bits select the sector.
// (R26) Blocked program still loads buffer.
// (R27) Commands ignored while busy; data bytes after 82/85 still load the buffer.
package fepp_pkg;
  localparam logic [7:0] OP_CE0 = 8'hC7;
  localparam logic [7:0] OP_CE1 = 8'h94;
  localparam logic [7:0] OP_CE2 = 8'h80;
  localparam logic [7:0] OP_CE3 = 8'h9A;
  localparam logic [7:0] OP_PB1 = 8'h82;
  localparam logic [7:0] OP_PB2 = 8'h85;
  localparam logic [7:0] OP_SP0 = 8'h3D;
  localparam logic [7:0] OP_SP1 = 8'h2A;
  localparam logic [7:0] OP_SP2 = 8'h7F;
  localparam logic [7:0] OP_SPEN = 8'hA9;
  localparam logic [7:0] OP_SPDIS = 8'h9A;
  localparam logic [7:0] MAP_PROT = 8'hFF;
  localparam int PAGE_W = 12;
  localparam int OFS_W = 9;
  localparam int NSECT = 16;
  localparam int ADDR_BYTES = 3;
  localparam int LAST_BIT = 7;
  localparam int SUB0A_HI = 7;
  localparam int SUB0A_LO = 6;
  localparam int SUB0B_HI = 5;
  localparam int SUB0B_LO = 4;
  localparam int BLK_SHIFT = 3;
  localparam int PAGE_264 = 264;
  localparam int PAGE_256 = 256;
  localparam int CLK_MHZ = 40;
  localparam int WP_FILT_NS = 1000;
  localparam int WP_FILT_CYC = (WP_FILT_NS * CLK_MHZ) / 1000;
  localparam int T_EP_US = 40000;
  localparam int T_CE_US = 200000;
  localparam int T_EP_CYC = T_EP_US * CLK_MHZ;
  localparam int T_CE_CYC = T_CE_US * CLK_MHZ;
  typedef enum logic [2:0] {ST_OPC, ST_SEQ, ST_ADDR, ST_DATA, ST_IGN} fepp_rx_t;
  typedef enum logic [1:0] {CMD_NONE, CMD_CE, CMD_PROG, CMD_SP} fepp_cmd_t;
endpackage

/* File: logic/fepp_core.sv */
// Serial command core: chip erase, page program via buffers, sector protection.
// Assumes serial pins are asynchronous and sampled here; the array is outside.
`timescale 1ns/1ps
module fepp_core
  import fepp_pkg::*;
#(
  parameter int EP_CYC   = T_EP_CYC,
  parameter int CE_CYC   = T_CE_CYC,
  parameter int FILT_CYC = WP_FILT_CYC
) (
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  input  wire logic              i_cs_n,
  input  wire logic              i_sck,
  input  wire logic              i_si,
  input  wire logic              i_wp_n,
  input  wire logic              i_page_264,
  input  wire logic [7:0]        i_map_byte [NSECT],
  input  wire logic [NSECT-1:0]  i_lockdown,
  output logic                   o_busy,
  output logic                   o_prot_enabled,
  output logic                   o_map_write_lock,
  output logic                   o_erase_start,
  output logic [NSECT:0]         o_erase_keep,
  output logic                   o_prog_start,
  output logic [PAGE_W-1:0]      o_prog_page,
  output logic                   o_prog_buf2,
  output logic                   o_buf_we,
  output logic                   o_buf_sel2,
  output logic [OFS_W-1:0]       o_buf_addr,
  output logic [7:0]             o_buf_data
);
  logic [1:0] cs_s_r, sck_s_r, si_s_r, wp_s_r;
  logic cs_d_r, sck_d_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cs_s_r  <= 2'h3;
      sck_s_r <= 2'h0;
      si_s_r  <= 2'h0;
      // (R16) pin idles high.
      wp_s_r  <= 2'h3;
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_s_r  <= {cs_s_r[0], i_cs_n};
      sck_s_r <= {sck_s_r[0], i_sck};
      si_s_r  <= {si_s_r[0], i_si};
      wp_s_r  <= {wp_s_r[0], i_wp_n};
      cs_d_r  <= cs_s_r[1];
      sck_d_r <= sck_s_r[1];
    end
  end
  logic cs_n, sck_rise, cs_rise;
  assign cs_n     = cs_s_r[1];
  assign sck_rise = sck_s_r[1] & ~sck_d_r & ~cs_n;
  assign cs_rise  = cs_n & ~cs_d_r;

  // (R20) write-protect noise filter.
  logic wp_filt_r;
  logic [$clog2(FILT_CYC+1)-1:0] wp_cnt_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wp_filt_r <= 1'b0;
      wp_cnt_r  <= '0;
    end else if (~wp_s_r[1] == wp_filt_r) begin
      wp_cnt_r <= '0;
    end else if (wp_cnt_r == ($clog2(FILT_CYC+1))'(FILT_CYC - 1)) begin
      wp_filt_r <= ~wp_s_r[1];
      wp_cnt_r  <= '0;
    end else begin
      wp_cnt_r <= wp_cnt_r + 1'b1;
    end
  end

  // Byte shifter.
  logic [2:0] bit_r;
  logic [6:0] sh_r;
  logic       byte_v;
  logic [7:0] byte_d;
  assign byte_v = sck_rise && bit_r == 3'(LAST_BIT);
  assign byte_d = {sh_r, si_s_r[1]};
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      bit_r <= '0;
      sh_r  <= '0;
    end else if (cs_n) begin
      bit_r <= '0;
    end else if (sck_rise) begin
      bit_r <= bit_r + 1'b1;
      sh_r  <= byte_d[6:0];
    end
  end

  fepp_rx_t rx_r;
  fepp_cmd_t cmd_r;
  logic [1:0] idx_r;
  logic [7:0] fin_r;
  logic armed_r, buf2_r;
  logic [23:0] addr_r;
  logic [OFS_W-1:0] ofs_r;
  logic [PAGE_W-1:0] page_r;
  logic busy_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_r    <= ST_OPC;
      cmd_r   <= CMD_NONE;
      idx_r   <= '0;
      fin_r   <= '0;
      armed_r <= 1'b0;
      buf2_r  <= 1'b0;
      addr_r  <= '0;
    end else if (cs_n) begin
      rx_r  <= ST_OPC;
      idx_r <= '0;
      if (cs_rise) begin
        armed_r <= 1'b0;
      end
    end else if (byte_v) begin
      case (rx_r)
        ST_OPC: begin
          armed_r <= 1'b0;
          idx_r   <= 2'd1;
          // (R1) first erase byte.
          if (byte_d == OP_CE0) begin
            cmd_r <= CMD_CE;
            rx_r  <= ST_SEQ;
          end else if (byte_d == OP_SP0) begin
            cmd_r <= CMD_SP;
            rx_r  <= ST_SEQ;
          // (R7) buffer select.
          end else if (byte_d == OP_PB1 || byte_d == OP_PB2) begin
            cmd_r  <= CMD_PROG;
            buf2_r <= byte_d == OP_PB2;
            idx_r  <= '0;
            rx_r   <= ST_ADDR;
          end else begin
            cmd_r <= CMD_NONE;
            rx_r  <= ST_IGN;
          end
        end
        ST_SEQ: begin
          idx_r <= idx_r + 1'b1;
          if (cmd_r == CMD_CE && idx_r == 2'd1 && byte_d == OP_CE1 ||
              cmd_r == CMD_CE && idx_r == 2'd2 && byte_d == OP_CE2 ||
              cmd_r == CMD_SP && idx_r == 2'd1 && byte_d == OP_SP1 ||
              cmd_r == CMD_SP && idx_r == 2'd2 && byte_d == OP_SP2) begin
            rx_r <= ST_SEQ;
          end else if (idx_r == 2'd3 && (cmd_r == CMD_CE && byte_d == OP_CE3 ||
                       cmd_r == CMD_SP && (byte_d == OP_SPEN || byte_d == OP_SPDIS))) begin
            // (R2) later bytes ignored.
            fin_r   <= byte_d;
            armed_r <= 1'b1;
            rx_r    <= ST_IGN;
          end else begin
            rx_r <= ST_IGN;
          end
        end
        ST_ADDR: begin
          addr_r <= {addr_r[15:0], byte_d};
          idx_r  <= idx_r + 1'b1;
          if (idx_r == 2'(ADDR_BYTES - 1)) begin
            rx_r    <= ST_DATA;
            armed_r <= 1'b1;
          end
        end
        ST_DATA: rx_r <= ST_DATA;
        ST_IGN:  rx_r <= ST_IGN;
        default: rx_r <= ST_IGN;
      endcase
    end
  end

  // (R8) (R9) address split per page size.
  logic [23:0] addr_full;
  assign addr_full = {addr_r[15:0], byte_d};
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ofs_r  <= '0;
      page_r <= '0;
    end else if (byte_v && rx_r == ST_ADDR && idx_r == 2'(ADDR_BYTES - 1)) begin
      if (i_page_264) begin
        page_r <= addr_full[OFS_W +: PAGE_W];
        ofs_r  <= addr_full[OFS_W-1:0];
      end else begin
        page_r <= addr_full[OFS_W-1 +: PAGE_W];
        ofs_r  <= {1'b0, addr_full[OFS_W-2:0]};
      end
    end else if (byte_v && rx_r == ST_DATA) begin
      // (R10) wrap at buffer end.
      if (i_page_264) begin
        ofs_r <= (ofs_r == OFS_W'(PAGE_264 - 1)) ? '0 : ofs_r + 1'b1;
      end else begin
        ofs_r <= (ofs_r == OFS_W'(PAGE_256 - 1)) ? '0 : ofs_r + 1'b1;
      end
    end
  end

  // (R26) buffer always written.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_buf_we   <= 1'b0;
      o_buf_sel2 <= 1'b0;
      o_buf_addr <= '0;
      o_buf_data <= '0;
    end else begin
      o_buf_we <= byte_v && rx_r == ST_DATA;
      if (byte_v && rx_r == ST_DATA) begin
        o_buf_sel2 <= buf2_r;
        o_buf_addr <= ofs_r;
        o_buf_data <= byte_d;
      end
    end
  end

  // Protection state.
  logic sw_prot_r, prot_en;
  // (R27) commands only when idle.
  logic take;
  assign take = cs_rise && armed_r && !busy_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      // (R15) software state cleared.
      sw_prot_r <= 1'b0;
    end else if (take && cmd_r == CMD_SP) begin
      // (R12) enable.
      if (fin_r == OP_SPEN) begin
        sw_prot_r <= 1'b1;
      // (R13) (R14) disable unless pin held.
      end else if (!wp_filt_r) begin
        sw_prot_r <= 1'b0;
      end
    end
  end
  // (R6) pin latched while busy.
  logic wp_eff_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wp_eff_r <= 1'b0;
    end else if (!busy_r) begin
      wp_eff_r <= wp_filt_r;
    end
  end
  // (R18) (R19) pin forces protection; release restores software state.
  assign prot_en = sw_prot_r | wp_eff_r;
  // (R21) status.
  assign o_prot_enabled = prot_en;
  // (R17) map locked by pin.
  assign o_map_write_lock = wp_eff_r;

  // (R23) (R24) (R25) per-sector protection view.
  logic [NSECT:0] prot_vec;
  genvar g;
  generate
    for (g = 1; g < NSECT; g++) begin : g_sect
      assign prot_vec[g+1] = prot_en && i_map_byte[g] == MAP_PROT;
    end
  endgenerate
  assign prot_vec[0] = prot_en && &i_map_byte[0][SUB0A_HI:SUB0A_LO];
  assign prot_vec[1] = prot_en && &i_map_byte[0][SUB0B_HI:SUB0B_LO];
  logic [3:0] sect;
  logic sub0b, page_prot;
  assign sect  = page_r[PAGE_W-1 -: 4];
  assign sub0b = |page_r[PAGE_W-5:BLK_SHIFT];
  // (R22) target protection check.
  assign page_prot = (sect == 4'h0) ? (sub0b ? prot_vec[1] : prot_vec[0]) : prot_vec[sect + 5'd1];

  // Self-timed cycle.
  logic [31:0] tmr_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      busy_r        <= 1'b0;
      tmr_r         <= '0;
      o_erase_start <= 1'b0;
      o_prog_start  <= 1'b0;
      o_erase_keep  <= '0;
      o_prog_page   <= '0;
      o_prog_buf2   <= 1'b0;
    end else begin
      o_erase_start <= 1'b0;
      o_prog_start  <= 1'b0;
      // (R3) chip erase on cs rise.
      if (take && cmd_r == CMD_CE) begin
        busy_r        <= 1'b1;
        tmr_r         <= 32'(CE_CYC);
        o_erase_start <= 1'b1;
        // (R5) keep protected and locked.
        o_erase_keep  <= prot_vec | {i_lockdown, i_lockdown[0]};
      // (R11) erase then program page.
      end else if (take && cmd_r == CMD_PROG && !page_prot) begin
        busy_r       <= 1'b1;
        tmr_r        <= 32'(EP_CYC);
        o_prog_start <= 1'b1;
        o_prog_page  <= page_r;
        o_prog_buf2  <= buf2_r;
      // (R4) busy until done.
      end else if (busy_r) begin
        tmr_r <= tmr_r - 1'b1;
        if (tmr_r == 32'd1) begin
          busy_r <= 1'b0;
        end
      end
    end
  end
  assign o_busy = busy_r;
endmodule

/* File: dv/fepp_core_asserts.sv */
// Port checker for the flash command core.
// Bound into every fepp_core instance.
`timescale 1ns/1ps
module fepp_core_asserts (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_wp_n,
  input wire logic o_busy,
  input wire logic o_prot_enabled,
  input wire logic o_map_write_lock,
  input wire logic o_erase_start,
  input wire logic o_prog_start,
  input wire logic o_buf_we
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  sequence s_wp_held;
    (!i_wp_n && !o_busy) [*8];
  endsequence
  sequence s_run;
    o_busy [*8];
  endsequence
  property p_ce_busy;
    o_erase_start |=> o_busy;
  endproperty
  a_ce_busy: assert property (p_ce_busy) else $error("erase without busy");
  property p_pulse;
    (o_erase_start || o_prog_start) |=> !(o_erase_start || o_prog_start);
  endproperty
  a_pulse: assert property (p_pulse) else $error("start held");
  property p_we;
    o_buf_we |=> !o_buf_we;
  endproperty
  a_we: assert property (p_we) else $error("buffer write held");
  property p_idle;
    o_busy && $past(o_busy) && $past(o_busy, 2) |-> !(o_erase_start || o_prog_start);
  endproperty
  a_idle: assert property (p_idle) else $error("start while busy");
  property p_len;
    $rose(o_busy) |-> s_run;
  endproperty
  a_len: assert property (p_len) else $error("busy too short");
  property p_wp;
    s_wp_held |-> ##[0:4] (o_map_write_lock && o_prot_enabled);
  endproperty
  a_wp: assert property (p_wp) else $error("pin did not protect");
  property p_lock_prot;
    o_map_write_lock |-> o_prot_enabled;
  endproperty
  a_lock_prot: assert property (p_lock_prot) else $error("lock without protection");
  property p_freeze;
    $rose(o_map_write_lock) |-> !$past(o_busy);
  endproperty
  a_freeze: assert property (p_freeze) else $error("lock during cycle");
  property p_filt;
    $rose(o_map_write_lock) |-> $past(!i_wp_n, 3) && $past(!i_wp_n, 4);
  endproperty
  a_filt: assert property (p_filt) else $error("pin not filtered");
endmodule
bind fepp_core fepp_core_asserts fepp_core_asserts_i (
  .i_clock(i_clock), .i_reset(i_reset), .i_wp_n(i_wp_n), .o_busy(o_busy),
  .o_prot_enabled(o_prot_enabled), .o_map_write_lock(o_map_write_lock),
  .o_erase_start(o_erase_start), .o_prog_start(o_prog_start), .o_buf_we(o_buf_we));

/* File: dv/fepp_host_model.sv */
// Serial host model driving chip select, clock and data.
// Assumes a 25 ns system clock; link clock is 200 ns.
`timescale 1ns/1ps
module fepp_host_model (
  input  wire logic i_clock,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge i_clock);
  endtask
  task automatic frame(input logic [7:0] q[$]);
    o_cs_n = 1'b0;
    half();
    foreach (q[j]) begin
      for (int i = 7; i >= 0; i--) begin
        o_si = q[j][i];
        half();
        o_sck = 1'b1;
        half();
        o_sck = 1'b0;
      end
    end
    o_cs_n = 1'b1;
    o_si   = ~o_si;
  endtask
endmodule

/* File: dv/fepp_core_tb.sv */
// Bench for the flash command core with a serial host model.
// Assumes the checker is bound in; map and lockdown are static levels.
`timescale 1ns/1ps
module fepp_core_tb;
  import fepp_pkg::*;
  logic clk, rst, wp_n, p264, cs_n, sck, si, busy, prot, mlk, est, pst, pb2, bwe, bs2;
  logic [7:0]       map [NSECT];
  logic [7:0]       bd;
  logic [8:0]       ba;
  logic [11:0]      pp;
  logic [NSECT:0]   ek;
  logic [NSECT-1:0] lock;
  logic [17:0]      bq [$];
  logic [12:0]      epg;
  int errors, tests_run, npst, nest, sw;
  int seed = 32'ha51f;
  fepp_host_model fepp_host_model_i (.i_clock(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  fepp_core #(.EP_CYC(50), .CE_CYC(600), .FILT_CYC(4)) fepp_core_i (
    .i_clock(clk), .i_reset(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(wp_n),
    .i_page_264(p264), .i_map_byte(map), .i_lockdown(lock), .o_busy(busy),
    .o_prot_enabled(prot), .o_map_write_lock(mlk), .o_erase_start(est), .o_erase_keep(ek),
    .o_prog_start(pst), .o_prog_page(pp), .o_prog_buf2(pb2), .o_buf_we(bwe),
    .o_buf_sel2(bs2), .o_buf_addr(ba), .o_buf_data(bd));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (e !== s) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wp(logic v, int n);
    wp_n = v;
    tick(n);
  endtask
  task automatic spc(logic [7:0] last);
    fepp_host_model_i.frame('{8'h3D, 8'h2A, 8'h7F, last});
    tick(8);
  endtask
  function automatic logic marked(logic [11:0] pg);
    if (pg[11:8] != 0) return map[pg[11:8]] == 8'hFF;
    return (pg[7:3] == 0) ? &map[0][7:6] : &map[0][5:4];
  endfunction
  task automatic prog(logic b2, logic s264, logic [11:0] pg);
    logic [7:0]  q [$];
    logic [23:0] a;
    logic [7:0]  d;
    int sz, n0;
    sz = s264 ? 264 : 256;
    p264 = s264;
    a = 24'($random(seed));
    a[20:0] = s264 ? {pg, 9'(sz - 2)} : {a[20], pg, 8'(sz - 2)};
    q = '{b2 ? 8'h85 : 8'h82, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      q.push_back(d);
      bq.push_back({b2, 9'((sz - 2 + i) % sz), d});
    end
    epg = {b2, pg};
    n0 = npst;
    fepp_host_model_i.frame(q);
    tick(8);
    chk("prog_start", !(sw && marked(pg)), npst - n0);
    chk("busy", !(sw && marked(pg)), busy);
    tick(60);
    chk("busy", 0, busy);
    chk("buffer", 0, bq.size());
  endtask
  always @(negedge clk) begin
    if (bwe === 1'b1) chk("buf_write", bq.size() ? bq.pop_front() : 18'h3_FFFF, {bs2, ba, bd});
    if (pst === 1'b1) chk("prog_page", epg, {pb2, pp});
    npst += (pst === 1'b1);
    nest += (est === 1'b1);
  end
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    tick(20000);
    errors++;
    final_report();
  end
  initial begin
    logic [NSECT:0] e;
    rst = 1; wp_n = 1; p264 = 1; lock = 16'h8000; sw = 0;
    foreach (map[s]) map[s] = (s == 0) ? 8'hC0 : (s % 2 ? 8'hFF : 8'h00);
    tick(10);
    rst = 0;
    tick(4);
    chk("prot", 0, prot);
    chk("map_lock", 0, mlk);
    wp(0, 2);
    wp(1, 10);
    chk("map_lock", 0, mlk);
    wp(0, 12);
    chk("prot", 1, prot);
    chk("map_lock", 1, mlk);
    spc(8'h9A);
    chk("prot", 1, prot);
    wp(1, 12);
    chk("prot", 0, prot);
    $display("test pin done");
    spc(8'hA9);
    sw = 1;
    chk("prot", 1, prot);
    wp(0, 12);
    wp(1, 12);
    chk("prot", 1, prot);
    spc(8'h9A);
    sw = 0;
    chk("prot", 0, prot);
    $display("test software done");
    for (int k = 0; k < 4; k++) prog(k[0], k[1], 12'($random(seed)) & 12'hEFF);
    spc(8'hA9);
    sw = 1;
    prog(1'b0, 1'b1, {4'h3, 8'($random(seed))});
    prog(1'b1, 1'b0, 12'h008);
    prog(1'b0, 1'b1, 12'h005);
    $display("test program done");
    fepp_host_model_i.frame('{8'h11, 8'hC7, 8'h94, 8'h80, 8'h9A});
    tick(8);
    chk("erase_start", 0, nest);
    fepp_host_model_i.frame('{8'hC7, 8'h94, 8'h80, 8'h9B});
    tick(8);
    chk("erase_start", 0, nest);
    fepp_host_model_i.frame('{8'hC7, 8'h94, 8'h80, 8'h9A, 8'h55, 8'hAA});
    tick(8);
    chk("erase_start", 1, nest);
    for (int s = 0; s <= NSECT; s++)
      e[s] = lock[s < 2 ? 0 : s - 1] | (sw != 0 && (s == 0 ? &map[0][7:6] : s == 1 ? &map[0][5:4] : &map[s - 1]));
    chk("erase_keep", e, ek);
    chk("busy", 1, busy);
    spc(8'h9A);
    chk("prot", 1, prot);
    wp(0, 12);
    chk("map_lock", 0, mlk);
    tick(400);
    chk("busy", 0, busy);
    chk("map_lock", 1, mlk);
    wp(1, 12);
    $display("test erase done");
    final_report();
  end
endmodule
